// [acg_cfg.svh]
// acg_cfg.svh: offsets, field positions, reset values and timing counts
// assumes a 200 MHz clk_sys; included by the acg_ctrl module only
`ifndef ACG_CFG_SVH
`define ACG_CFG_SVH

// register offsets (register index on the plain port)
`define ACG_ADDR_CTL1 4'h1
`define ACG_ADDR_CTL2 4'h2
`define ACG_ADDR_CTL3 4'h3
`define ACG_ADDR_HI 4'h4
`define ACG_ADDR_LO 4'h5
`define ACG_ADDR_RES 4'hc

// reset values
`define ACG_CTL1_RST 16'h0000
`define ACG_CTL2_RST 16'h4040
`define ACG_CTL3_RST 16'h0000
`define ACG_LIM_RST 16'h0000
`define ACG_RES_RST 16'h0000

// control_one fields
`define ACG_B_ALERT_FN 15
`define ACG_F_CHSEL 14:12
`define ACG_F_MODE 11:10
`define ACG_F_ACQ 9:8
`define ACG_F_TMR 7:0
`define ACG_MODE_MANUAL 2'h1
`define ACG_MODE_REPEAT 2'h2

// control_two fields
`define ACG_B_GPIO_EN 13
`define ACG_B_GPIO_DAT 12
`define ACG_B_GPIO_DIR 11
`define ACG_B_PIN_POLARITY_BIT 10
`define ACG_F_MED 6:5
`define ACG_F_FCD 2:0

// control_three fields
`define ACG_B_HI_ST 15
`define ACG_B_LO_ST 14
`define ACG_B_GPIO_MASK 12
`define ACG_B_HI_EN 11
`define ACG_B_LO_EN 10
`define ACG_F_SEQ 5:0

// converter channel codes
`define ACG_CH_TEMP 3'h1
`define ACG_CH_BAT 3'h2
`define ACG_CH_AUX 3'h3
`define ACG_CH_Z2 3'h4
`define ACG_CH_Z1 3'h5
`define ACG_CH_Y 3'h6
`define ACG_CH_X 3'h7

// times in ns and derived cycle counts
`define ACG_CLK_NS 5
`define ACG_T_ACQ_BASE_NS 2000
`define ACG_T_ACQ_TEMP_NS 16000
`define ACG_T_CONV_NS 7500
`define ACG_T_SORT_NS 2000
`define ACG_T_FCD_STEP_NS 128000
`define ACG_T_TMR_STEP_NS 36800
`define ACG_ACQ_BASE_CYC ((`ACG_T_ACQ_BASE_NS + `ACG_CLK_NS - 1) / `ACG_CLK_NS)
`define ACG_ACQ_TEMP_CYC ((`ACG_T_ACQ_TEMP_NS + `ACG_CLK_NS - 1) / `ACG_CLK_NS)
`define ACG_CONV_CYC ((`ACG_T_CONV_NS + `ACG_CLK_NS - 1) / `ACG_CLK_NS)
`define ACG_SORT_CYC ((`ACG_T_SORT_NS + `ACG_CLK_NS - 1) / `ACG_CLK_NS)
`define ACG_FCD_STEP_CYC ((`ACG_T_FCD_STEP_NS + `ACG_CLK_NS - 1) / `ACG_CLK_NS)
`define ACG_TMR_STEP_CYC (`ACG_T_TMR_STEP_NS / `ACG_CLK_NS)

`endif

// [acg_pkg.sv]
// acg_pkg: types shared by the control block and its surroundings
// assumes acg_cfg.svh is on the include path
package acg_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETTLE, ST_ACQ, ST_CONV, ST_SORT, ST_TRAIL, ST_WAIT
    } acg_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } acg_bus_req_t;

    typedef struct packed {
        logic acq_en;
        logic divider_en;
        logic strobe;
        logic [2:0] chan;
    } acg_conv_t;
endpackage : acg_pkg

// [acg_ctrl.sv]
// acg_ctrl: register file, limit check, general-purpose pin and sequencer
// assumes one 200 MHz clock, synchronous inputs and an external converter
// that presents adc_data in every cycle in which conv.strobe is high
//
// Contract
// R1: divider on only while acquiring battery
// R2: code 010 converts battery into result
// R3: shared high and low limits registers
// R4: compare each aux/battery result, set flags
// R5: flag alerts only if function and enable
// R6: pin enable bit gates all pin config
// R7: pin data held in control_two bit 12
// R8: direction bit: 0 output, 1 input follows
// R9: polarity 1 maps data to pin directly
// R10: polarity 0 inverts both directions
// R11: control_three bit 12 masks pin alert
// R12: pin alert only in input mode set
// R13: pin alert held until pin or enable changes
// R14: settle before screen channels, once otherwise
// R15: trailing settle after the last channel
// R16: measurement is acquisition, conversion, sort
// R17: temperature uses fixed 16 us acquisition
// R18: median off skips sort time
// R19: channel repeats median count times
// R20: up to six channels, settle, idle timer
// R21: code 011 converts auxiliary into result
// R22: repeat starts only after idle timer
`timescale 1ns/100ps
`include "acg_cfg.svh"

module acg_ctrl #(
    parameter int FCD_STEP_CYC = `ACG_FCD_STEP_CYC,
    parameter int TMR_STEP_CYC = `ACG_TMR_STEP_CYC,
    parameter int CNT_W = 22
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // register port
    input acg_pkg::acg_bus_req_t req,
    output logic [15:0] reg_rdata,
    // converter
    output acg_pkg::acg_conv_t conv,
    input wire logic [11:0] adc_data,
    // multifunction pin and alert
    input wire logic gpio_in,
    output logic gpio_out,
    output logic gpio_oe,
    output logic alert_n
);
    import acg_pkg::*;

    logic [15:0] ctl1_r, ctl1_nxt, ctl2_r, ctl2_nxt, ctl3_r, ctl3_nxt;
    logic [15:0] hi_r, hi_nxt, lo_r, lo_nxt, res_r, res_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic gal_r, gal_nxt, alert_n_r, alert_n_nxt;
    logic gout_r, gout_nxt, goe_r, goe_nxt;
    logic pin_d_r, en_d_r, cond_d_r, cond;
    acg_state_t st_r, st_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [5:0] pend_r, pend_nxt, rest;
    logic [2:0] code_r, code_nxt;
    logic [4:0] rep_r, rep_nxt, med_cnt;
    acg_conv_t conv_r, conv_nxt;
    logic go, man_go, done, store;
    logic [15:0] len_r;

    function automatic logic [2:0] lowest(input logic [5:0] m);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 5; i >= 0; i--) begin
            if (m[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : lowest

    function automatic logic [2:0] slot_code(input logic [2:0] s,
                                             input logic [2:0] sel);
        logic [2:0] c;
        unique case (s)
            3'h0: c = `ACG_CH_X;
            3'h1: c = `ACG_CH_Y;
            3'h2: c = `ACG_CH_Z1;
            3'h3: c = `ACG_CH_Z2;
            3'h4: c = (sel == `ACG_CH_BAT) ? `ACG_CH_BAT : `ACG_CH_AUX;
            default: c = `ACG_CH_TEMP;
        endcase
        return c;
    endfunction : slot_code

    // cycles minus one, so a state lasts exactly the figure
    function automatic logic [CNT_W-1:0] acq_cyc(input logic [2:0] c,
                                                 input logic [1:0] a);
        int n;
        n = (`ACG_ACQ_BASE_CYC << a) - 1;
        if (c == `ACG_CH_TEMP) begin
            n = `ACG_ACQ_TEMP_CYC - 1; // [R17]
        end
        return CNT_W'(n);
    endfunction : acq_cyc

    logic [CNT_W-1:0] fcd_cyc, tmr_cyc;
    assign fcd_cyc = CNT_W'((int'(ctl2_r[`ACG_F_FCD]) + 1) * FCD_STEP_CYC - 1);
    assign tmr_cyc = CNT_W'(int'(ctl1_r[`ACG_F_TMR]) * TMR_STEP_CYC - 1);

    // median setting: off, 4, 8, 16 measurements per channel
    always_comb begin
        unique case (ctl2_r[`ACG_F_MED])
            2'h0: med_cnt = 5'd1;
            2'h1: med_cnt = 5'd4;
            2'h2: med_cnt = 5'd8;
            default: med_cnt = 5'd16;
        endcase
    end

    assign man_go = req.wr && req.addr == `ACG_ADDR_CTL1
        && req.wdata[`ACG_F_MODE] == `ACG_MODE_MANUAL;
    assign go = man_go || (ctl1_r[`ACG_F_MODE] == `ACG_MODE_REPEAT
        && ctl3_r[`ACG_F_SEQ] != 6'h00);
    assign rest = pend_r & (pend_r - 6'h01);

    // sequencer
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
        pend_nxt = pend_r;
        code_nxt = code_r;
        rep_nxt = rep_r;
        done = 1'b0;
        unique case (st_r)
            ST_IDLE: begin
                if (go) begin
                    pend_nxt = man_go ? 6'h01 : ctl3_r[`ACG_F_SEQ]; // [R20]
                    code_nxt = man_go ? req.wdata[`ACG_F_CHSEL]
                        : slot_code(lowest(ctl3_r[`ACG_F_SEQ]),
                                    ctl1_r[`ACG_F_CHSEL]); // [R2] [R21]
                    st_nxt = ST_SETTLE; // [R14]
                    cnt_nxt = fcd_cyc;
                end
            end
            ST_SETTLE: begin
                if (cnt_r == '0) begin
                    st_nxt = ST_ACQ;
                    cnt_nxt = acq_cyc(code_r, ctl1_r[`ACG_F_ACQ]);
                    rep_nxt = med_cnt; // [R19]
                end
            end
            ST_ACQ: begin
                if (cnt_r == '0) begin
                    st_nxt = ST_CONV;
                    cnt_nxt = CNT_W'(`ACG_CONV_CYC - 1); // [R16]
                end
            end
            ST_CONV: begin
                if (cnt_r == '0) begin
                    if (ctl2_r[`ACG_F_MED] != 2'h0) begin
                        st_nxt = ST_SORT;
                        cnt_nxt = CNT_W'(`ACG_SORT_CYC - 1); // [R16]
                    end else begin
                        done = 1'b1; // [R18]
                    end
                end
            end
            ST_SORT: begin
                done = (cnt_r == '0);
            end
            ST_TRAIL: begin
                if (cnt_r == '0) begin
                    st_nxt = ST_IDLE;
                    if (ctl1_r[`ACG_F_MODE] == `ACG_MODE_REPEAT
                        && ctl1_r[`ACG_F_TMR] != 8'h00) begin
                        st_nxt = ST_WAIT; // [R20]
                        cnt_nxt = tmr_cyc;
                    end
                end
            end
            ST_WAIT: begin
                if (cnt_r == '0) begin
                    st_nxt = ST_IDLE; // [R22]
                end
            end
        endcase
        if (done) begin
            if (rep_r > 5'd1) begin
                rep_nxt = rep_r - 5'd1; // [R19]
                st_nxt = ST_ACQ;
                cnt_nxt = acq_cyc(code_r, ctl1_r[`ACG_F_ACQ]);
            end else if (rest != 6'h00) begin
                pend_nxt = rest;
                code_nxt = slot_code(lowest(rest), ctl1_r[`ACG_F_CHSEL]);
                rep_nxt = med_cnt;
                if (code_nxt[2]) begin
                    st_nxt = ST_SETTLE; // [R14]
                    cnt_nxt = fcd_cyc;
                end else begin
                    st_nxt = ST_ACQ;
                    cnt_nxt = acq_cyc(code_nxt, ctl1_r[`ACG_F_ACQ]);
                end
            end else begin
                pend_nxt = 6'h00;
                st_nxt = ST_TRAIL; // [R15]
                cnt_nxt = fcd_cyc;
            end
        end
        conv_nxt.acq_en = (st_nxt == ST_ACQ);
        conv_nxt.divider_en = (st_nxt == ST_ACQ)
            && (code_nxt == `ACG_CH_BAT); // [R1]
        conv_nxt.strobe = (st_nxt == ST_CONV) && (cnt_nxt == '0);
        conv_nxt.chan = code_nxt;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_r <= ST_IDLE;
            cnt_r <= '0;
            pend_r <= 6'h00;
            code_r <= 3'h0;
            rep_r <= 5'd0;
            conv_r <= '0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            pend_r <= pend_nxt;
            code_r <= code_nxt;
            rep_r <= rep_nxt;
            conv_r <= conv_nxt;
        end
    end

    // last measurement of an auxiliary or battery channel is kept
    assign store = st_r == ST_CONV && cnt_r == '0 && rep_r == 5'd1
        && (code_r == `ACG_CH_BAT || code_r == `ACG_CH_AUX);
    assign cond = ctl2_r[`ACG_B_GPIO_EN] && ctl2_r[`ACG_B_GPIO_DIR]
        && ctl2_r[`ACG_B_GPIO_DAT]; // [R12]

    // registers, limit flags, pin and alert
    always_comb begin
        ctl1_nxt = ctl1_r;
        ctl2_nxt = ctl2_r;
        ctl3_nxt = ctl3_r;
        hi_nxt = hi_r;
        lo_nxt = lo_r;
        res_nxt = res_r;
        rdata_nxt = 16'h0000;
        if (req.wr) begin
            unique case (req.addr)
                `ACG_ADDR_CTL1: ctl1_nxt = req.wdata;
                `ACG_ADDR_CTL2: ctl2_nxt = req.wdata; // [R7]
                `ACG_ADDR_CTL3: begin
                    ctl3_nxt = req.wdata;
                    ctl3_nxt[`ACG_B_HI_ST] = ctl3_r[`ACG_B_HI_ST]
                        && !req.wdata[`ACG_B_HI_ST];
                    ctl3_nxt[`ACG_B_LO_ST] = ctl3_r[`ACG_B_LO_ST]
                        && !req.wdata[`ACG_B_LO_ST];
                end
                `ACG_ADDR_HI: hi_nxt = req.wdata; // [R3]
                `ACG_ADDR_LO: lo_nxt = req.wdata; // [R3]
                default: ;
            endcase
        end
        if (ctl2_r[`ACG_B_GPIO_EN] && ctl2_r[`ACG_B_GPIO_DIR]) begin
            // input mode: pin owns the data bit [R8] [R9] [R10]
            ctl2_nxt[`ACG_B_GPIO_DAT] = gpio_in ^ !ctl2_r[`ACG_B_PIN_POLARITY_BIT];
        end
        if (store) begin
            res_nxt = {4'h0, adc_data}; // [R2] [R21]
            if ({4'h0, adc_data} > hi_r) begin
                ctl3_nxt[`ACG_B_HI_ST] = 1'b1; // [R4]
            end
            if ({4'h0, adc_data} < lo_r) begin
                ctl3_nxt[`ACG_B_LO_ST] = 1'b1; // [R4]
            end
        end
        if (req.rd) begin
            unique case (req.addr)
                `ACG_ADDR_CTL1: rdata_nxt = ctl1_r;
                `ACG_ADDR_CTL2: rdata_nxt = ctl2_r;
                `ACG_ADDR_CTL3: rdata_nxt = ctl3_r;
                `ACG_ADDR_HI: rdata_nxt = hi_r;
                `ACG_ADDR_LO: rdata_nxt = lo_r;
                `ACG_ADDR_RES: rdata_nxt = res_r;
                default: rdata_nxt = 16'h0000;
            endcase
        end
        // pin alert: set when the condition rises, held until pin or enable moves
        gal_nxt = gal_r;
        if (gpio_in != pin_d_r || ctl2_r[`ACG_B_GPIO_EN] != en_d_r) begin
            gal_nxt = 1'b0; // [R13]
        end
        if (cond && !cond_d_r) begin
            gal_nxt = 1'b1; // [R12]
        end
        alert_n_nxt = !(ctl1_r[`ACG_B_ALERT_FN]
            && ((ctl3_r[`ACG_B_HI_ST] && ctl3_r[`ACG_B_HI_EN])
                || (ctl3_r[`ACG_B_LO_ST] && ctl3_r[`ACG_B_LO_EN])
                || (gal_r && !ctl3_r[`ACG_B_GPIO_MASK]))); // [R5] [R11]
        goe_nxt = ctl2_r[`ACG_B_GPIO_EN] && !ctl2_r[`ACG_B_GPIO_DIR]; // [R6]
        gout_nxt = goe_nxt
            && (ctl2_r[`ACG_B_GPIO_DAT] ^ !ctl2_r[`ACG_B_PIN_POLARITY_BIT]); // [R10]
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctl1_r <= `ACG_CTL1_RST;
            ctl2_r <= `ACG_CTL2_RST;
            ctl3_r <= `ACG_CTL3_RST;
            hi_r <= `ACG_LIM_RST;
            lo_r <= `ACG_LIM_RST;
            res_r <= `ACG_RES_RST;
            rdata_r <= 16'h0000;
            gal_r <= 1'b0;
            alert_n_r <= 1'b1;
            goe_r <= 1'b0;
            gout_r <= 1'b0;
            pin_d_r <= 1'b0;
            en_d_r <= 1'b0;
            cond_d_r <= 1'b0;
        end else begin
            ctl1_r <= ctl1_nxt;
            ctl2_r <= ctl2_nxt;
            ctl3_r <= ctl3_nxt;
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
            res_r <= res_nxt;
            rdata_r <= rdata_nxt;
            gal_r <= gal_nxt;
            alert_n_r <= alert_n_nxt;
            goe_r <= goe_nxt;
            gout_r <= gout_nxt;
            pin_d_r <= gpio_in;
            en_d_r <= ctl2_r[`ACG_B_GPIO_EN];
            cond_d_r <= cond;
        end
    end

    assign reg_rdata = rdata_r;
    assign conv = conv_r;
    assign gpio_out = gout_r;
    assign gpio_oe = goe_r;
    assign alert_n = alert_n_r;

    // helper: cycles spent in the current sequencer state
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            len_r <= 16'h0001;
        end else if (st_nxt != st_r) begin
            len_r <= 16'h0001;
        end else begin
            len_r <= len_r + 16'h0001;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence conv_end_s;
        st_r == ST_CONV && cnt_r == '0;
    endsequence
    sequence last_chan_s;
        done && rep_r == 5'd1 && rest == 6'h00;
    endsequence

    divider_gate_a: assert property (conv.divider_en |-> conv.acq_en // [R1]
        && conv.chan == `ACG_CH_BAT) else $error("divider on outside bat");
    result_store_a: assert property (store |=> // [R2]
        res_r == {4'h0, $past(adc_data)}) else $error("result not stored");
    limit_write_a: assert property (req.wr && req.addr == `ACG_ADDR_LO // [R3]
        |=> lo_r == $past(req.wdata)) else $error("low limit lost");
    high_flag_a: assert property (store && {4'h0, adc_data} > hi_r // [R4]
        |=> ctl3_r[`ACG_B_HI_ST]) else $error("high flag not set");
    alert_fn_a: assert property (!ctl1_r[`ACG_B_ALERT_FN] |=> alert_n) // [R5]
        else $error("alert without function");
    pin_off_a: assert property (!ctl2_r[`ACG_B_GPIO_EN] |=> !gpio_oe // [R6]
        && !gal_r) else $error("pin active while disabled");
    pin_follow_a: assert property (ctl2_r[`ACG_B_GPIO_EN] // [R8]
        && ctl2_r[`ACG_B_GPIO_DIR] |=> ctl2_r[`ACG_B_GPIO_DAT]
        == ($past(gpio_in) ^ !$past(ctl2_r[`ACG_B_PIN_POLARITY_BIT])))
        else $error("pin data not following");
    pin_mask_a: assert property (ctl3_r[`ACG_B_GPIO_MASK] // [R11]
        && !ctl3_r[`ACG_B_HI_ST] && !ctl3_r[`ACG_B_LO_ST] |=> alert_n)
        else $error("masked pin alert");
    out_mode_a: assert property (!ctl2_r[`ACG_B_GPIO_DIR] // [R12]
        && $stable(gpio_in) && $stable(ctl2_r[`ACG_B_GPIO_EN])
        |=> !$rose(gal_r)) else $error("output mode alert");
    first_settle_a: assert property (st_r == ST_IDLE && go // [R14]
        |=> st_r == ST_SETTLE) else $error("no leading settle");
    trail_settle_a: assert property (last_chan_s |=> // [R15]
        st_r == ST_TRAIL) else $error("no trailing settle");
    conv_len_a: assert property (conv_end_s |-> // [R16]
        len_r == 16'(`ACG_CONV_CYC)) else $error("conversion length");
    temp_acq_a: assert property (st_r == ST_ACQ && cnt_r == '0 // [R17]
        && code_r == `ACG_CH_TEMP |-> len_r == 16'(`ACG_ACQ_TEMP_CYC))
        else $error("temperature acquisition length");
    sort_skip_a: assert property (ctl2_r[`ACG_F_MED] == 2'h0 // [R18]
        and conv_end_s |=> st_r != ST_SORT) else $error("sort not skipped");
    repeat_cnt_a: assert property (done && rep_r > 5'd1 // [R19]
        |=> st_r == ST_ACQ && rep_r == $past(rep_r) - 5'd1)
        else $error("repeat count");
    idle_wait_a: assert property (st_r == ST_WAIT && cnt_r != '0 // [R22]
        |=> st_r == ST_WAIT) else $error("sequence restarted early");
endmodule : acg_ctrl

// [acg_adc_model.sv]
// acg_adc_model: behavioural converter on the conversion link
// assumes conv from acg_ctrl; the bench sets the level to return
`timescale 1ns/100ps
module acg_adc_model (
    // clock and bench control
    input wire logic clk_sys,
    input wire logic clr,
    input wire logic [11:0] level,
    // converter link
    input acg_pkg::acg_conv_t conv,
    output logic [11:0] adc_data,
    // observations
    output int acq_len,
    output int acq_period,
    output int strobes,
    output int div_cnt
);
    import acg_pkg::*;
    int run_cnt;
    int gap_cnt;
    bit acq_q;
    always @(posedge clk_sys) begin
        acq_q <= conv.acq_en;
        gap_cnt <= gap_cnt + 1;
        run_cnt <= run_cnt + int'(conv.acq_en);
        if (conv.acq_en && !acq_q) begin
            acq_period <= gap_cnt;
            gap_cnt <= 1;
            run_cnt <= 1;
        end
        if (!conv.acq_en && acq_q) begin
            acq_len <= run_cnt;
        end
        div_cnt <= clr ? 0 : div_cnt + int'(conv.divider_en);
        strobes <= clr ? 0 : strobes + int'(conv.strobe);
    end
    // off the strobe the result lines show a pattern that moves each cycle
    assign adc_data = conv.strobe ? level : ~level ^ gap_cnt[11:0];
endmodule : acg_adc_model

// [tb.sv]
// tb: self-checking bench for acg_ctrl with a behavioural converter
// assumes acg_pkg and shortened settle and idle timer steps
`timescale 1ns/100ps
module tb;
    import acg_pkg::*;
    localparam int STEP = 4;
    localparam int SAMPLE_WINDOW_TIME = 400;
    localparam int SORT = 400;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    acg_bus_req_t req = '0;
    acg_conv_t conv;
    logic [15:0] reg_rdata;
    logic [11:0] adc_data;
    logic [11:0] level = 12'h000;
    logic gpio_in = 1'b0;
    logic gpio_out;
    logic gpio_oe;
    logic alert_n;
    logic clr = 1'b0;
    int acq_len;
    int acq_period;
    int strobes;
    int div_cnt;
    int errors = 0;
    int total_checks = 0;
    int p0;
    int p1;
    int p2;

    always #2.5 clk_sys = ~clk_sys;

    acg_ctrl #(.FCD_STEP_CYC(STEP), .TMR_STEP_CYC(STEP)) dut (
        .clk_sys(clk_sys), .srst(srst), .req(req),
        .reg_rdata(reg_rdata), .conv(conv), .adc_data(adc_data),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .alert_n(alert_n));
    acg_adc_model adc (
        .clk_sys(clk_sys), .clr(clr), .level(level), .conv(conv),
        .adc_data(adc_data), .acq_len(acq_len), .acq_period(acq_period),
        .strobes(strobes), .div_cnt(div_cnt));

    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clk_sys);
        req.wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input string what, input logic [3:0] a,
                      input logic [15:0] exp);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 chk(what, reg_rdata, exp);
        @(posedge clk_sys);
    endtask : rd

    // start a run and wait, bounded, for n conversion strobes
    task automatic run_seq(input logic [15:0] c1, input int n);
        int k;
        k = 0;
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
        wr(4'h1, c1);
        while (strobes < n && k < 60000) begin
            @(posedge clk_sys);
            k++;
        end
        // a median run still sorts after its last strobe
        tick(SORT + 3 * STEP + 10);
        chk("strobes", 16'(strobes), 16'(n));
    endtask : run_seq

    task automatic t_reset;
        chk("alert_n", 16'(alert_n), 16'h0001);
        chk("gpio_oe", 16'(gpio_oe), 16'h0000);
        rd("control_one", 4'h1, 16'h0000);
        rd("control_two", 4'h2, 16'h4040);
        rd("control_three", 4'h3, 16'h0000);
        rd("high limit", 4'h4, 16'h0000);
        rd("low limit", 4'h5, 16'h0000);
        rd("result", 4'hc, 16'h0000);
    endtask : t_reset

    task automatic t_limits;
        wr(4'h4, 16'h0abc);
        wr(4'h5, 16'h0123);
        wr(4'hf, 16'hffff);
        wr(4'hc, 16'h0555);
        rd("high limit", 4'h4, 16'h0abc);
        rd("low limit", 4'h5, 16'h0123);
        rd("unmapped", 4'hf, 16'h0000);
        rd("result ro", 4'hc, 16'h0000);
    endtask : t_limits

    task automatic t_gpio;
        wr(4'h1, 16'h8000);
        wr(4'h2, 16'h1400);
        tick(3);
        chk("oe pin off", 16'(gpio_oe), 16'h0000);
        wr(4'h2, 16'h3400);
        tick(3);
        chk("oe output", 16'(gpio_oe), 16'h0001);
        chk("out pol1", 16'(gpio_out), 16'h0001);
        chk("alert out mode", 16'(alert_n), 16'h0001);
        wr(4'h2, 16'h3000);
        tick(3);
        chk("out pol0", 16'(gpio_out), 16'h0000);
        rd("pin data", 4'h2, 16'h3000);
        gpio_in <= 1'b1;
        wr(4'h2, 16'h2c00);
        tick(3);
        chk("oe input", 16'(gpio_oe), 16'h0000);
        rd("in pol1", 4'h2, 16'h3c00);
        chk("alert pin", 16'(alert_n), 16'h0000);
        wr(4'h2, 16'h2c00);
        rd("data ro", 4'h2, 16'h3c00);
        wr(4'h3, 16'h1000);
        tick(3);
        chk("alert masked", 16'(alert_n), 16'h0001);
        wr(4'h3, 16'h0000);
        tick(3);
        chk("alert held", 16'(alert_n), 16'h0000);
        gpio_in <= 1'b0;
        tick(3);
        chk("alert pin edge", 16'(alert_n), 16'h0001);
        wr(4'h2, 16'h2800);
        rd("in pol0", 4'h2, 16'h3800);
        tick(3);
        chk("alert pol0", 16'(alert_n), 16'h0000);
        wr(4'h2, 16'h0800);
        tick(3);
        chk("alert pin off", 16'(alert_n), 16'h0001);
        wr(4'h1, 16'h0000);
    endtask : t_gpio

    task automatic t_limit_alerts;
        wr(4'h2, 16'h0000);
        wr(4'h4, 16'h0100);
        wr(4'h5, 16'h0010);
        wr(4'h3, 16'h0c00);
        level <= 12'h200;
        run_seq(16'ha400, 1);
        chk("divider bat", 16'(div_cnt), 16'(SAMPLE_WINDOW_TIME));
        rd("bat result", 4'hc, 16'h0200);
        rd("high flag", 4'h3, 16'h8c00);
        chk("alert high", 16'(alert_n), 16'h0000);
        wr(4'h3, 16'h0400);
        tick(3);
        chk("alert off", 16'(alert_n), 16'h0001);
        wr(4'h3, 16'h8c00);
        rd("high clear", 4'h3, 16'h0c00);
        level <= 12'h008;
        run_seq(16'hb400, 1);
        chk("divider aux", 16'(div_cnt), 16'h0000);
        rd("aux result", 4'hc, 16'h0008);
        rd("low flag", 4'h3, 16'h4c00);
        chk("alert low", 16'(alert_n), 16'h0000);
        wr(4'h3, 16'h4000);
        rd("low clear", 4'h3, 16'h0000);
        chk("alert clear", 16'(alert_n), 16'h0001);
    endtask : t_limit_alerts

    task automatic t_timing;
        for (int c = 0; c < 4; c++) begin
            run_seq({4'h3, 2'h1, 2'(c), 8'h00}, 1);
            chk("acq cycles", 16'(acq_len), 16'(SAMPLE_WINDOW_TIME << c));
        end
        run_seq(16'h1400, 1);
        chk("temp acq", 16'(acq_len), 16'(SAMPLE_WINDOW_TIME * 8));
        for (int m = 0; m < 3; m++) begin
            wr(4'h2, {9'h000, 2'(m), 5'h00});
            run_seq(16'h3400, (m == 0) ? 1 : (2 << m));
            if (m > 0) begin
                chk("acq period", 16'(acq_period), 16'(SAMPLE_WINDOW_TIME + 1900));
            end
        end
    endtask : t_timing

    task automatic rep_period(input logic [2:0] fcd, input logic [7:0] tmr,
                              output int p);
        wr(4'h2, {13'h0000, fcd});
        wr(4'h3, 16'h0010);
        run_seq({4'h3, 2'h2, 2'h0, tmr}, 3);
        p = acq_period;
        wr(4'h1, 16'h0000);
        tick(3000);
    endtask : rep_period

    task automatic t_repeat;
        rep_period(3'h0, 8'h00, p0);
        rep_period(3'h1, 8'h00, p1);
        rep_period(3'h0, 8'h05, p2);
        chk("settle steps", 16'(p1 - p0), 16'(2 * STEP));
        chk("idle timer", 16'(p2 - p0), 16'(5 * STEP));
    endtask : t_repeat

    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    initial begin
        tick(20);
        srst <= 1'b0;
        tick(1);
        t_reset();
        t_limits();
        t_gpio();
        t_limit_alerts();
        t_timing();
        t_repeat();
        final_report();
    end

    // the whole run needs about 82000 cycles
    initial begin
        tick(95000);
        errors++;
        final_report();
    end
endmodule : tb
